//--- osl_unit.v
/*
 Output signal logic unit: function multiplexing for one output terminal and one
 relay, a two-operand combiner, link timeout flag, start command indicator,
 overheat warning and low current flag, with a simple register port and
 interrupt. Assumes synchronous inputs on i_core_clk at 100 MHz; the other
 output functions arrive on i_func_bus.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
`include "osl_consts.vh"

module osl_unit (
  // Clock and reset
  input  wire                    i_core_clk,
  input  wire                    i_sys_rst,
  // Register port
  input  wire [`OSL_ADDR_W-1:0]  i_addr,
  input  wire [31:0]             i_wdata,
  input  wire                    i_wr,
  input  wire                    i_rd,
  output reg  [31:0]             o_rdata,
  // Other output functions, indexed by code
  input  wire [63:0]             i_func_bus,
  // Drive state
  input  wire                    i_forward_command,
  input  wire                    i_reverse_command,
  input  wire                    i_running,
  input  wire                    i_constant_speed,
  input  wire                    i_modbus_rtu,
  input  wire                    i_rx_data,
  input  wire [`OSL_TEMP_W-1:0]  i_heatsink_temp,
  input  wire [`OSL_CUR_W-1:0]   i_output_current,
  // Outputs
  output reg                     o_terminal,
  output reg                     o_relay,
  output reg                     o_link_timeout_flag,
  output reg                     o_start_command_present,
  output reg                     o_overheat_warning,
  output reg                     o_low_current_flag,
  output reg                     o_combined,
  output reg                     o_motor_stop,
  output reg                     o_irq
);

  // Settings
  reg  [`OSL_FN_W-1:0]   output_terminal_function;
  reg  [`OSL_FN_W-1:0]   relay_function;
  reg  [`OSL_FN_W-1:0]   operand_a_select;
  reg  [`OSL_FN_W-1:0]   operand_b_select;
  reg  [1:0]             operator_select;
  reg                    low_current_mode;
  reg  [`OSL_TMO_W-1:0]  timeout_limit_setting;
  reg  [`OSL_TEMP_W-1:0] overheat_threshold;
  reg  [`OSL_CUR_W-1:0]  low_current_level;
  reg  [`OSL_IRQ_W-1:0]  irq_status;
  reg  [`OSL_IRQ_W-1:0]  irq_mask;

  // Timeout counting
  reg  [`OSL_TICK_W-1:0] tick_cnt;
  reg  [`OSL_TMO_W-1:0]  tmo_cnt;

  // Flag events and previous levels
  reg                    prev_tmo;
  reg                    prev_ovh;
  reg                    prev_loc;
  reg                    prev_both;

  wire [`OSL_FN_W-1:0]   wr_a = i_wdata[`OSL_F_A_HI:`OSL_F_A_LO];
  wire [`OSL_FN_W-1:0]   wr_b = i_wdata[`OSL_F_B_HI:`OSL_F_B_LO];

  // Operand legal when in range and not combiner or unassigned
  function legal_operand;
    input [`OSL_FN_W-1:0] code;
    begin
      legal_operand = (code <= `OSL_FN_MAX) && (code != `OSL_FN_COMBINE);
    end
  endfunction

  // Full function vector with this block's own signals
  reg  [63:0]            func_vec;
  wire                   both_cmds = i_forward_command & i_reverse_command;
  always @* begin
    func_vec = i_func_bus;
    func_vec[`OSL_FN_LINK_TMO]  = o_link_timeout_flag;
    func_vec[`OSL_FN_COMBINE]   = o_combined;
    func_vec[`OSL_FN_START_CMD] = o_start_command_present;
    func_vec[`OSL_FN_OVERHEAT]  = o_overheat_warning;
    func_vec[`OSL_FN_LOW_CUR]   = o_low_current_flag;
    func_vec[`OSL_FN_UNASSIGNED] = 1'b0;
  end

  reg next_combined;
  always @* begin
    case (operator_select)
      `OSL_OP_AND: next_combined = func_vec[operand_a_select] & func_vec[operand_b_select];
      `OSL_OP_OR:  next_combined = func_vec[operand_a_select] | func_vec[operand_b_select];
      `OSL_OP_XOR: next_combined = func_vec[operand_a_select] ^ func_vec[operand_b_select];
      default:     next_combined = 1'b0;
    endcase
  end

  wire next_start = i_forward_command ^ i_reverse_command;
  wire next_ovh   = i_heatsink_temp > overheat_threshold;
  wire lc_enable  = (low_current_mode == `OSL_LC_ALWAYS) ? i_running
                                                         : (i_running & i_constant_speed);
  wire next_loc   = lc_enable && (i_output_current <= low_current_level);

  // Reception timeout: 10 ms tick, counter of ticks since last data
  wire tick     = (tick_cnt == `OSL_TICK_CYC - 1);
  wire tmo_hit  = i_modbus_rtu && !i_rx_data && (tmo_cnt >= timeout_limit_setting);

  always @(posedge i_core_clk) begin
    if (i_sys_rst || i_rx_data || !i_modbus_rtu) begin
      tick_cnt <= {`OSL_TICK_W{1'b0}};
      tmo_cnt  <= {`OSL_TMO_W{1'b0}};
    end else begin
      tick_cnt <= tick ? {`OSL_TICK_W{1'b0}} : tick_cnt + 1'b1;
      if (tick && tmo_cnt != `OSL_TMO_MAX)
        tmo_cnt <= tmo_cnt + 1'b1;
    end
  end

  // Registered flags and terminal outputs
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_link_timeout_flag     <= 1'b0;
      o_start_command_present <= 1'b0;
      o_overheat_warning      <= 1'b0;
      o_low_current_flag      <= 1'b0;
      o_combined              <= 1'b0;
      o_motor_stop            <= 1'b0;
      o_terminal              <= 1'b0;
      o_relay                 <= 1'b0;
    end else begin
      if (!i_modbus_rtu || i_rx_data)
        o_link_timeout_flag <= 1'b0;
      else if (tmo_hit)
        o_link_timeout_flag <= 1'b1;
      o_start_command_present <= next_start;
      o_motor_stop            <= both_cmds;
      o_overheat_warning      <= next_ovh;
      o_low_current_flag      <= next_loc;
      o_combined              <= next_combined;
      o_terminal              <= func_vec[output_terminal_function];
      o_relay                 <= func_vec[relay_function];
    end
  end

  // Interrupt events on rising flags; set wins over clear
  wire [`OSL_IRQ_W-1:0] events = {both_cmds & ~prev_both,
                                  next_loc & ~prev_loc,
                                  next_ovh & ~prev_ovh,
                                  o_link_timeout_flag & ~prev_tmo};
  wire [`OSL_IRQ_W-1:0] clr = (i_wr && i_addr == `OSL_R_IRQ_ST) ? i_wdata[`OSL_IRQ_W-1:0]
                                                                : {`OSL_IRQ_W{1'b0}};

  // Per-bit sticky status; an event in the cycle of its clear keeps the bit set
  wire [`OSL_IRQ_W-1:0] next_status;
  genvar gi;
  generate
    for (gi = 0; gi < `OSL_IRQ_W; gi = gi + 1) begin : g_irq
      assign next_status[gi] = events[gi] | (irq_status[gi] & ~clr[gi]);
    end
  endgenerate

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      prev_tmo   <= 1'b0;
      prev_ovh   <= 1'b0;
      prev_loc   <= 1'b0;
      prev_both  <= 1'b0;
      irq_status <= {`OSL_IRQ_W{1'b0}};
      o_irq      <= 1'b0;
    end else begin
      prev_tmo   <= o_link_timeout_flag;
      prev_ovh   <= next_ovh;
      prev_loc   <= next_loc;
      prev_both  <= both_cmds;
      irq_status <= next_status;
      o_irq      <= |(next_status & irq_mask);
    end
  end

  // Register writes; illegal operand or out-of-range values are ignored
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      output_terminal_function <= `OSL_FN_RUN;
      relay_function           <= `OSL_FN_RUN;
      operand_a_select         <= `OSL_FN_RUN;
      operand_b_select         <= `OSL_FN_RUN;
      operator_select          <= `OSL_OP_AND;
      low_current_mode         <= `OSL_LC_ALWAYS;
      timeout_limit_setting    <= {`OSL_TMO_W{1'b0}};
      overheat_threshold       <= {`OSL_TEMP_W{1'b0}};
      low_current_level        <= {`OSL_CUR_W{1'b0}};
      irq_mask                 <= {`OSL_IRQ_W{1'b0}};
    end else if (i_wr) begin
      case (i_addr)
        `OSL_R_SEL: begin
          if (legal_operand(wr_a))
            operand_a_select <= wr_a;
          if (legal_operand(wr_b))
            operand_b_select <= wr_b;
          if (i_wdata[`OSL_F_OP_HI:`OSL_F_OP_LO] <= `OSL_OP_XOR)
            operator_select <= i_wdata[`OSL_F_OP_HI:`OSL_F_OP_LO];
        end
        `OSL_R_CFG: begin
          if (wr_a <= `OSL_FN_MAX)
            output_terminal_function <= wr_a;
          if (wr_b <= `OSL_FN_MAX)
            relay_function <= wr_b;
          low_current_mode <= i_wdata[`OSL_F_MODE];
        end
        `OSL_R_TMO: begin
          if (i_wdata[`OSL_F_TMO_HI:`OSL_F_TMO_LO] <= `OSL_TMO_MAX)
            timeout_limit_setting <= i_wdata[`OSL_F_TMO_HI:`OSL_F_TMO_LO];
        end
        `OSL_R_THR: begin
          if (i_wdata[`OSL_F_TEMP_HI:`OSL_F_TEMP_LO] <= `OSL_TEMP_MAX)
            overheat_threshold <= i_wdata[`OSL_F_TEMP_HI:`OSL_F_TEMP_LO];
          if (i_wdata[`OSL_F_CUR_HI:`OSL_F_CUR_LO] <= `OSL_CUR_MAX)
            low_current_level <= i_wdata[`OSL_F_CUR_HI:`OSL_F_CUR_LO];
        end
        `OSL_R_IRQ_MASK: irq_mask <= i_wdata[`OSL_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge i_core_clk) begin
    if (i_sys_rst || !i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      case (i_addr)
        `OSL_R_SEL:      o_rdata <= {14'h0000, operator_select, 2'h0, operand_b_select, 2'h0, operand_a_select};
        `OSL_R_CFG:      o_rdata <= {15'h0000, low_current_mode, 2'h0, relay_function,
                                     2'h0, output_terminal_function};
        `OSL_R_TMO:      o_rdata <= {18'h00000, timeout_limit_setting};
        `OSL_R_THR:      o_rdata <= {16'h0000, low_current_level, overheat_threshold};
        `OSL_R_STAT:     o_rdata <= {24'h000000, o_motor_stop, o_combined, o_relay, o_terminal,
                                     o_low_current_flag, o_overheat_warning,
                                     o_start_command_present, o_link_timeout_flag};
        `OSL_R_IRQ_ST:   o_rdata <= {28'h0000000, irq_status};
        `OSL_R_IRQ_MASK: o_rdata <= {28'h0000000, irq_mask};
        `OSL_R_TMO_CNT:  o_rdata <= {18'h00000, tmo_cnt};
        default:         o_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- osl_consts.vh
/*
 Constants for the output signal logic unit: function codes, settings encodings,
 timing figures. Assumes inclusion by osl_unit.v only.
*/
`ifndef OSL_CONSTS_VH
`define OSL_CONSTS_VH

// Function codes of output terminal and relay
`define OSL_FN_W          6
`define OSL_FN_MAX        6'h3C
`define OSL_FN_RUN        6'h00
`define OSL_FN_LINK_TMO   6'h20
`define OSL_FN_COMBINE    6'h21
`define OSL_FN_START_CMD  6'h29
`define OSL_FN_OVERHEAT   6'h2A
`define OSL_FN_LOW_CUR    6'h2B
`define OSL_FN_UNASSIGNED 6'h3F

// Write data field positions
`define OSL_F_A_HI        5
`define OSL_F_A_LO        0
`define OSL_F_B_HI        13
`define OSL_F_B_LO        8
`define OSL_F_OP_HI       17
`define OSL_F_OP_LO       16
`define OSL_F_MODE        16
`define OSL_F_TMO_HI      13
`define OSL_F_TMO_LO      0
`define OSL_F_TEMP_HI     7
`define OSL_F_TEMP_LO     0
`define OSL_F_CUR_HI      15
`define OSL_F_CUR_LO      8

// Operator codes
`define OSL_OP_AND        2'h0
`define OSL_OP_OR         2'h1
`define OSL_OP_XOR        2'h2

// Low current modes
`define OSL_LC_ALWAYS     1'h0
`define OSL_LC_CONST      1'h1

// Timeout setting in units of 10 ms, 0 to 9999
`define OSL_TMO_W         14
`define OSL_TMO_MAX       14'h270F
`define OSL_TMO_UNIT_NS   10000000
`define OSL_CLK_NS        10
`define OSL_TICK_CYC      (`OSL_TMO_UNIT_NS / `OSL_CLK_NS)
`define OSL_TICK_W        20

// Temperature in degrees C, current as level in 1/100 of rated
`define OSL_TEMP_W        8
`define OSL_TEMP_MAX      8'h6E
`define OSL_CUR_W         8
`define OSL_CUR_MAX       8'hC8

// Interrupt bit positions
`define OSL_IRQ_W         4
`define OSL_IRQ_TMO       0
`define OSL_IRQ_OVH       1
`define OSL_IRQ_LOC       2
`define OSL_IRQ_BOTH      3

// Register offsets
`define OSL_ADDR_W        4
`define OSL_R_SEL         4'h0
`define OSL_R_CFG         4'h1
`define OSL_R_TMO         4'h2
`define OSL_R_THR         4'h3
`define OSL_R_STAT        4'h4
`define OSL_R_IRQ_ST      4'h5
`define OSL_R_IRQ_MASK    4'h6
`define OSL_R_TMO_CNT     4'h7

`endif

//--- osl_unit_sva.sv
/*
 Port checker for osl_unit, bound to every instance.
 Assumes one clock domain with a synchronous active-high reset.
*/
module osl_unit_chk (
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_forward_command,
  input wire logic       i_reverse_command,
  input wire logic       i_running,
  input wire logic       i_modbus_rtu,
  input wire logic       i_rx_data,
  input wire logic [7:0] i_heatsink_temp,
  input wire logic [7:0] i_output_current,
  input wire logic       o_link_timeout_flag,
  input wire logic       o_start_command_present,
  input wire logic       o_overheat_warning,
  input wire logic       o_low_current_flag,
  input wire logic       o_motor_stop
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence both_run;
    i_forward_command && i_reverse_command;
  endsequence

  a_start_xor: assert property (!$past(i_sys_rst) |->
    o_start_command_present == $past(i_forward_command ^ i_reverse_command)) else $error("start flag wrong");
  a_both_stop: assert property (both_run ##1 both_run |->
    o_motor_stop && !o_start_command_present) else $error("both run not stopped");
  a_ovh_cold: assert property (i_heatsink_temp == 8'h00 |=> !o_overheat_warning)
    else $error("overheat at zero");
  a_loc_idle: assert property (!i_running |=> !o_low_current_flag) else $error("low current idle");
  a_loc_high: assert property (i_output_current > 8'hC8 |=> !o_low_current_flag)
    else $error("low current above max");
  a_tmo_rtu: assert property (!i_modbus_rtu |=> !o_link_timeout_flag) else $error("timeout off");
  a_tmo_rx: assert property (i_rx_data |=> !o_link_timeout_flag) else $error("timeout kept");
  a_reset_clear: assert property ($fell(i_sys_rst) |->
    !(o_start_command_present | o_link_timeout_flag | o_overheat_warning | o_low_current_flag | o_motor_stop))
    else $error("outputs not cleared");
endmodule

bind osl_unit osl_unit_chk u_chk (.i_core_clk, .i_sys_rst, .i_forward_command, .i_reverse_command, .i_running,
  .i_modbus_rtu, .i_rx_data, .i_heatsink_temp, .i_output_current, .o_link_timeout_flag,
  .o_start_command_present, .o_overheat_warning, .o_low_current_flag, .o_motor_stop);

//--- osl_ctrl_model.sv
/*
 External controller model: latches run and receive requests onto drive inputs.
 Assumes requests change just after a rising edge.
*/
module osl_ctrl_model (
  input  wire logic i_clk,
  input  wire logic i_fw_req,
  input  wire logic i_rv_req,
  input  wire logic i_rx_req,
  output logic      o_fw,
  output logic      o_rv,
  output logic      o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge i_clk) begin
    o_fw <= i_fw_req;
    o_rv <= i_rv_req;
    o_rx <= i_rx_req;
  end
endmodule

//--- osl_unit_tb_top.sv
/*
 Testbench for osl_unit: register port stimulus, flag and routing checks.
 Assumes the controller model and the bound checker.
*/
module osl_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk, i_sys_rst, i_wr, i_rd, i_running, i_constant_speed, i_modbus_rtu;
  logic        cmd_fw, cmd_rv, cmd_rx, i_forward_command, i_reverse_command, i_rx_data, irq0;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rd_val;
  logic [63:0] i_func_bus;
  logic [7:0]  i_heatsink_temp, i_output_current;
  logic        o_terminal, o_relay, o_link_timeout_flag, o_start_command_present;
  logic        o_overheat_warning, o_low_current_flag, o_combined, o_motor_stop, o_irq;
  int          num_errors, compares;

  osl_unit dut (.i_core_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_func_bus,
    .i_forward_command, .i_reverse_command, .i_running, .i_constant_speed, .i_modbus_rtu, .i_rx_data,
    .i_heatsink_temp, .i_output_current, .o_terminal, .o_relay, .o_link_timeout_flag,
    .o_start_command_present, .o_overheat_warning, .o_low_current_flag, .o_combined, .o_motor_stop, .o_irq);
  osl_ctrl_model u_ctrl (.i_clk(i_core_clk), .i_fw_req(cmd_fw), .i_rv_req(cmd_rv), .i_rx_req(cmd_rx),
    .o_fw(i_forward_command), .o_rv(i_reverse_command), .o_rx(i_rx_data));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask

  task automatic settle;
    repeat (4) @(posedge i_core_clk);
    #1;
  endtask

  task automatic t_combiner;
    logic e;
    wr(4'h1, 32'h0000_2121);
    for (int op = 0; op < 3; op++) begin
      for (int ab = 0; ab < 4; ab++) begin
        wr(4'h0, 32'h0000_0705 | (op << 16));
        i_func_bus <= (64'(ab & 1) << 5) | (64'(ab >> 1) << 7);
        settle();
        e = (op == 0) ? (ab == 3) : (op == 1) ? (ab != 0) : (ab == 1 || ab == 2);
        chk(o_combined, e);
        chk(o_terminal, e);
      end
    end
    wr(4'h0, 32'h0000_0721);
    rd(4'h0);
    chk(rd_val, 32'h0000_0705);
  endtask

  task automatic t_start;
    wr(4'h1, 32'h0000_0029);
    for (int i = 0; i < 4; i++) begin
      cmd_fw <= i[0];
      cmd_rv <= i[1];
      settle();
      chk(o_start_command_present, i[0] ^ i[1]);
      chk(o_terminal, i[0] ^ i[1]);
      chk(o_motor_stop, i[0] & i[1]);
    end
    cmd_fw <= 1'b0;
    cmd_rv <= 1'b0;
  endtask

  task automatic t_timeout;
    wr(4'h1, 32'h0000_2000);
    wr(4'h2, 32'h0000_2710);
    rd(4'h2);
    chk(rd_val, 32'h0);
    wr(4'h2, 32'h0000_270F);
    rd(4'h2);
    chk(rd_val, 32'h0000_270F);
    wr(4'h2, 32'h0);
    i_modbus_rtu <= 1'b1;
    settle();
    chk(o_link_timeout_flag, 1'b1);
    chk(o_relay, 1'b1);
    cmd_rx <= 1'b1;
    settle();
    chk(o_link_timeout_flag, 1'b0);
    cmd_rx <= 1'b0;
    settle();
    chk(o_link_timeout_flag, 1'b1);
    i_modbus_rtu <= 1'b0;
  endtask

  task automatic t_overheat;
    wr(4'h1, 32'h0000_002A);
    wr(4'h3, 32'h0000_3264);
    wr(4'h3, 32'h0000_C96F);
    for (int i = 0; i < 2; i++) begin
      i_heatsink_temp <= 8'h64 + 8'(i);
      settle();
      chk(o_overheat_warning, i);
      chk(o_terminal, i);
    end
  endtask

  task automatic t_lowcur;
    logic [11:0] tbl [6] = '{12'h132, 12'h133, 12'h000, 12'h100, 12'h132, 12'h1C9};
    logic [5:0]  res = 6'b010001;
    logic [5:0]  mode = 6'b011000;
    logic [5:0]  cs = 6'b010000;
    wr(4'h1, 32'h0000_2B00);
    for (int i = 0; i < 6; i++) begin
      wr(4'h1, 32'h0000_2B00 | (32'(mode[i]) << 16));
      i_running        <= tbl[i][8];
      i_constant_speed <= cs[i];
      i_output_current <= tbl[i][7:0];
      settle();
      chk(o_low_current_flag, res[i]);
      chk(o_relay, res[i]);
    end
  endtask

  task automatic t_irq;
    rd(4'h5);
    chk(rd_val[1], 1'b1);
    i_heatsink_temp <= 8'h00;
    i_running       <= 1'b0;
    wr(4'h6, 32'h0);
    settle();
    irq0 = o_irq;
    wr(4'h6, 32'h0000_000F);
    settle();
    chk(irq0 ^ o_irq, 1'b1);
    wr(4'h5, 32'h0000_000F);
    settle();
    rd(4'h5);
    chk(rd_val, 32'h0);
    chk(o_irq, 1'b0);
    rd(4'h8);
    chk(rd_val, 32'h0);
  endtask

  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {i_sys_rst, i_wr, i_rd, i_running, i_constant_speed, i_modbus_rtu} = 6'b100000;
    {cmd_fw, cmd_rv, cmd_rx, i_addr, i_wdata, i_func_bus} = '0;
    {i_heatsink_temp, i_output_current} = '0;
    repeat (8) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(4'h4);
    chk(rd_val, 32'h0);
    t_combiner();
    t_start();
    t_timeout();
    t_overheat();
    t_lowcur();
    t_irq();
    wrap_up();
  end
endmodule
